// ### rst_regs.vh
// Register map, field positions, codes and timing constants for reset and sleep control.
// ====================================================================
// Behaviour
// R1: Five reset causes: supply-on, pin, watchdog, brown-out, scan-port register; any holds reset.
// R2: During reset I/O registers take initial values; release starts at reset vector.
// R3: I/O ports reset asynchronously the moment any cause activates, no clock needed; here the watchdog cause passes clocked flops first.
// R4: After all causes end, delay counter stretches internal reset; fuses set period.
// R5: Reset pin low longer than minimum pulse length gives external reset.
// R6: Watchdog reset only when watchdog enabled and its timeout elapsed.
// R7: Brown-out reset while detector enabled and supply below trigger threshold.
// R8: Reset held while scan-port reset register bit holds one.
// R9: Supply-on reset asserted whenever supply low, reasserted at once on new drop.
// R10: Supply rising past threshold starts the delay counter.
// R11: Comparator disabled automatically in every sleep mode except Idle.
// R12: Comparator using internal reference keeps reference on in sleep unless disabled.
// R13: Brown-out detector enabled by level fuses stays active in all sleep modes.
// R14: Enabled watchdog stays active in all sleep modes.
// R15: Reference enabled only while brown-out detector or comparator needs it.
// R16: Sleep modes stopping I/O clock disable input buffers; wake-up inputs stay on.
// R17: Debug fuse set keeps main clock running in Power-down and Power-save; here only while the scan port is also active.
// R18: Scan-port disable bit or unprogrammed enable fuse disables the scan port.
// R19: Scan port enabled but not shifting leaves TDO undriven.
// R20: Sleep select codes: Idle 000, Power-down 010, Power-save 011.
// R21: Watchdog timeout gives one-cycle pulse; delay starts at its falling edge.
// R22: Each cause sets own flag; write zero clears; supply-on clears others.
// R23: Causes combine asynchronously; internal reset release synchronised to clock.
// R24: Delay terminal count from clock-select fuses; restarts when any cause reasserts.
`ifndef RST_REGS_VH
`define RST_REGS_VH

// ====================================================================
// Register offsets (byte addresses).
`define REG_STATUS_FLAGS 12'h000
`define REG_SLEEP_CTRL   12'h004
`define REG_CTRL         12'h008
`define REG_STATE        12'h00c

// ====================================================================
// Reset flag bits.
`define FLG_POR   0
`define FLG_EXT   1
`define FLG_BOR   2
`define FLG_WDT   3
`define FLG_SCAN  4
`define FLG_W     5
`define FLG_RST   5'h00

// ====================================================================
// Sleep control fields.
`define SLP_SEL_LO 0
`define SLP_SEL_HI 2
`define SLP_EN     3
`define SLP_RST    4'h0

// ====================================================================
// Control fields.
`define CTL_SCAN_DIS  0
`define CTL_WDT_EN    1
`define CTL_CMP_DIS   2
`define CTL_CMP_BG    3
`define CTL_RST       4'h0

// ====================================================================
// Sleep select codes.
`define SM_IDLE      3'h0
`define SM_PWR_DOWN  3'h2
`define SM_PWR_SAVE  3'h3
`define SM_STANDBY   3'h6
`define SM_EXT_STBY  3'h7

// Brown-out level fuse code that means detector off.
`define BOD_OFF 3'h7

// Address where execution begins after reset.
`define RESET_VECTOR 16'h0000

// ====================================================================
// Timing.
`define CLK_MHZ    200
`define T_RST_NS   2500
`define T_RST_CYC  ((`T_RST_NS * `CLK_MHZ + 999) / 1000)

`endif

// ### sync_2ff.v
// Two flip-flop level synchroniser for a bus of independent bits.
`timescale 1ns/1ps
`default_nettype none
module sync_2ff #(
  parameter W = 1
) (
  input  wire         clk,     // destination clock
  input  wire         rst_n,   // asynchronous reset, active low
  input  wire [W-1:0] d,       // asynchronous levels
  output reg  [W-1:0] q        // synchronised levels
);

  reg [W-1:0] meta_q;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= {W{1'b0}};
      q      <= {W{1'b0}};
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule
`default_nettype wire

// ### pulse_filter.v
// Minimum pulse width qualifier for a synchronised active-high level.
`timescale 1ns/1ps
`default_nettype none
module pulse_filter #(
  parameter MIN_CYC = 500,
  parameter CW      = 10
) (
  input  wire clk,      // clock
  input  wire rst_n,    // asynchronous reset, active low
  input  wire level,    // synchronised input level
  output reg  qualified // high once level has stood MIN_CYC cycles
);

  reg [CW-1:0] cnt_q;

  // The count saturates, so a level held for ever cannot wrap and drop out.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q     <= {CW{1'b0}};
      qualified <= 1'b0;
    end else if (!level) begin
      cnt_q     <= {CW{1'b0}};
      qualified <= 1'b0;
    end else if (cnt_q >= MIN_CYC[CW-1:0] - 1'b1) begin
      qualified <= 1'b1; // [R5]
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

endmodule
`default_nettype wire

// ### reset_sleep_ctrl.v
// Reset generation, reset stretching and sleep power gating with APB registers.
//
// Decided for this implementation: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "rst_regs.vh"
module reset_sleep_ctrl #(
  parameter TW    = 24,        // delay counter width
  parameter TOUT0 = 24'd6,     // time-out in cycles, fuse group 0
  parameter TOUT1 = 24'd4096,  // time-out in cycles, fuse group 1
  parameter TOUT2 = 24'd820000,   // time-out in cycles, fuse group 2
  parameter TOUT3 = 24'd13000000  // time-out in cycles, fuse group 3
) (
  input  wire        pclk,                 // system clock
  input  wire        presetn,              // bus reset, active low
  input  wire        psel,                 // APB select
  input  wire        penable,              // APB enable
  input  wire        pwrite,               // APB direction
  input  wire [11:0] paddr,                // APB byte address
  input  wire [31:0] pwdata,               // APB write data
  output reg  [31:0] prdata,               // APB read data
  output wire        pready,               // APB ready
  output wire        pslverr,              // APB error
  input  wire        supply_low,           // supply detector below level
  input  wire        rst_pin_n,            // external reset pin
  input  wire        wdt_timeout,          // watchdog period elapsed
  input  wire        bod_below,            // supply below brown-out level
  input  wire        scan_reset_bit,       // scan-port reset register bit
  input  wire [2:0]  brownout_level_fuses, // brown-out level fuses
  input  wire [3:0]  clock_select_fuses,   // clock select fuses
  input  wire        debug_enable_fuse,    // on-chip debug fuse
  input  wire        scan_port_enable_fuse,// scan port fuse
  input  wire        sleep_cmd,            // CPU sleep instruction pulse
  input  wire        wake_event,           // wake-up condition
  input  wire        tap_shifting,         // TAP shifting data
  input  wire        tdo_data,             // TDO data from TAP
  output wire        io_reset_n,           // I/O port reset, async
  output reg         cpu_reset_n,          // stretched internal reset
  output reg         vector_load,          // pulse: load reset vector
  output reg  [15:0] vector_addr,          // reset vector address
  output wire        tdo_o,                // TDO output value
  output wire        tdo_oe,               // TDO output enable
  output wire        scan_port_active,     // scan interface enabled
  output reg         comparator_en,        // analog comparator power
  output reg         vref_en,              // internal reference power
  output reg         bod_active,           // brown-out detector power
  output reg         wdt_active,           // watchdog power
  output reg         input_buf_en,         // digital input buffers
  output reg         wake_buf_en,          // wake-up input logic
  output reg         io_clk_en,            // peripheral_io_clock gate
  output reg         main_clk_en           // main clock source enable
);

  // ==================================================================
  // Helpers.

  function [TW-1:0] tout_sel;
    input [3:0] f;
    begin
      case (f[1:0])
        2'h0:    tout_sel = TOUT0;
        2'h1:    tout_sel = TOUT1;
        2'h2:    tout_sel = TOUT2;
        default: tout_sel = TOUT3;
      endcase
    end
  endfunction

  // Modes that stop the peripheral_io_clock: every sleep mode but Idle.
  function deep_mode;
    input [2:0] m;
    begin
      case (m)
        `SM_PWR_DOWN, `SM_PWR_SAVE, `SM_STANDBY, `SM_EXT_STBY:
          deep_mode = 1'b1;
        default:
          deep_mode = 1'b0;
      endcase
    end
  endfunction

  // ==================================================================
  // Registers and state.

  reg [`FLG_W-1:0] flags_q;
  reg [3:0]        slp_q;
  reg [3:0]        ctl_q;
  reg              sleeping_q;
  reg              wd_pulse_q;
  reg              wd_prev_q;
  reg [1:0]        hold_sync_q;
  reg [TW-1:0]     cnt_q;
  reg              stretch_q;
  reg              hold_prev_q;

  wire [4:0] raw_lv;
  wire [4:0] syn_lv;
  wire       pin_cause;
  wire       por_s;
  wire       bor_s;
  wire       scan_s;
  wire       wd_s;
  wire       wake_s;
  wire       pin_low_s;

  // ==================================================================
  // Synchronised copies of the asynchronous inputs.

  assign raw_lv = {wake_event, scan_reset_bit, wdt_timeout,
                   ~rst_pin_n, supply_low};

  sync_2ff #(
    .W (5)
  ) u_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .d     (raw_lv),
    .q     (syn_lv)
  );

  assign por_s     = syn_lv[0];
  assign pin_low_s = syn_lv[1];
  assign wd_s      = syn_lv[2];
  assign scan_s    = syn_lv[3] & scan_port_active;
  assign wake_s    = syn_lv[4];

  // The brown-out comparator output is a second analog level; it gets its
  // own pair of flops so it cannot be merged with the pin timing.
  wire bod_en = (brownout_level_fuses != `BOD_OFF);
  wire bor_raw = bod_en & bod_below;
  wire bor_syn;

  sync_2ff #(
    .W (1)
  ) u_sync_bod (
    .clk   (pclk),
    .rst_n (presetn),
    .d     (bor_raw),
    .q     (bor_syn)
  );

  assign bor_s = bor_syn & bod_en; // [R7]

  pulse_filter #(
    .MIN_CYC (`T_RST_CYC),
    .CW      (10)
  ) u_pin_filt (
    .clk       (pclk),
    .rst_n     (presetn),
    .level     (pin_low_s),
    .qualified (pin_cause) // [R5]
  );

  // ==================================================================
  // Watchdog reset pulse.

  // Only the rising edge of the expiry level counts, giving exactly one
  // reset cycle; its falling edge then lets the stretch counter start.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wd_prev_q  <= 1'b0;
      wd_pulse_q <= 1'b0;
    end else begin
      wd_prev_q  <= wd_s;
      wd_pulse_q <= wd_s & ~wd_prev_q & ctl_q[`CTL_WDT_EN]; // [R6] [R21]
    end
  end

  // ==================================================================
  // Cause combination.

  // The I/O ports see the raw pin and supply levels with no clock in the
  // path, so a reset reaches them even while every clock is stopped.
  wire scan_raw = scan_reset_bit & scan_port_active;
  wire io_cause = supply_low | ~rst_pin_n | bor_raw | wd_pulse_q | scan_raw;

  assign io_reset_n = ~io_cause; // [R3] [R9]

  wire int_cause = supply_low | bor_raw | wd_pulse_q | scan_raw | pin_cause;
  wire hold_set  = int_cause | ~presetn; // [R1] [R8] [R23]

  // Assertion is asynchronous; release passes two flops.
  always @(posedge pclk or posedge hold_set) begin
    if (hold_set) begin
      hold_sync_q <= 2'b11; // [R23]
    end else begin
      hold_sync_q <= {hold_sync_q[0], 1'b0};
    end
  end

  wire hold = hold_sync_q[1];

  // ==================================================================
  // Delay counter.

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q     <= {TW{1'b0}};
      stretch_q <= 1'b1;
    end else if (hold) begin
      cnt_q     <= {TW{1'b0}}; // [R24]
      stretch_q <= 1'b1;
    end else if (stretch_q) begin
      if (cnt_q >= tout_sel(clock_select_fuses) - 1'b1) begin // [R4] [R24]
        stretch_q <= 1'b0;
      end else begin
        cnt_q <= cnt_q + 1'b1; // [R10]
      end
    end
  end

  // ==================================================================
  // Internal reset and reset vector.

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_prev_q <= 1'b1;
      cpu_reset_n <= 1'b0;
      vector_load <= 1'b0;
      vector_addr <= `RESET_VECTOR;
    end else begin
      hold_prev_q <= hold | stretch_q;
      cpu_reset_n <= ~(hold | stretch_q); // [R4]
      vector_load <= hold_prev_q & ~(hold | stretch_q); // [R2]
      vector_addr <= `RESET_VECTOR; // [R2]
    end
  end

  // ==================================================================
  // Reset flags.

  wire [`FLG_W-1:0] flag_set;
  assign flag_set = {scan_s, wd_pulse_q, bor_s, pin_cause, por_s}; // [R22]

  wire wr_acc = psel & penable & pwrite;
  wire wr_flg = wr_acc & (paddr == `REG_STATUS_FLAGS);

  // A set in the cycle of a clearing write wins over that write.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_q <= `FLG_RST;
    end else if (por_s) begin
      flags_q <= {{(`FLG_W-1){1'b0}}, 1'b1}; // [R22]
    end else if (wr_flg) begin
      flags_q <= (flags_q & pwdata[`FLG_W-1:0]) | flag_set; // [R22]
    end else begin
      flags_q <= flags_q | flag_set; // [R22]
    end
  end

  // ==================================================================
  // Control registers.

  // These are I/O registers, so every reset cause returns them to their
  // initial values; only the bus reset and a cause can clear them.
  wire regs_rst = ~presetn | io_cause;

  always @(posedge pclk or posedge regs_rst) begin
    if (regs_rst) begin
      slp_q <= `SLP_RST; // [R2]
      ctl_q <= `CTL_RST; // [R2]
    end else if (wr_acc && paddr == `REG_SLEEP_CTRL) begin
      slp_q <= pwdata[3:0];
    end else if (wr_acc && paddr == `REG_CTRL) begin
      ctl_q <= pwdata[3:0];
    end
  end

  // ==================================================================
  // Sleep state.

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleeping_q <= 1'b0;
    end else if (!cpu_reset_n || wake_s) begin
      sleeping_q <= 1'b0;
    end else if (sleep_cmd && slp_q[`SLP_EN]) begin
      sleeping_q <= 1'b1;
    end
  end

  wire [2:0] mode = slp_q[`SLP_SEL_HI:`SLP_SEL_LO]; // [R20]
  wire       deep = sleeping_q & deep_mode(mode);
  wire       cmp_want = ~ctl_q[`CTL_CMP_DIS];
  wire       pd_ps = sleeping_q &
                     (mode == `SM_PWR_DOWN || mode == `SM_PWR_SAVE); // [R20]

  // ==================================================================
  // Power gating outputs.

  // The reference stays on in deep sleep whenever the comparator is enabled and wired
  // to it, even though the comparator itself is then powered down.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      comparator_en <= 1'b0;
      vref_en       <= 1'b0;
      bod_active    <= 1'b0;
      wdt_active    <= 1'b0;
      input_buf_en  <= 1'b1;
      wake_buf_en   <= 1'b1;
      io_clk_en     <= 1'b1;
      main_clk_en   <= 1'b1;
    end else begin
      comparator_en <= cmp_want & ~deep; // [R11]
      vref_en       <= bod_en |
                       (cmp_want & ctl_q[`CTL_CMP_BG]); // [R12] [R15]
      bod_active    <= bod_en; // [R13]
      wdt_active    <= ctl_q[`CTL_WDT_EN]; // [R14]
      input_buf_en  <= ~deep; // [R16]
      wake_buf_en   <= 1'b1; // [R16]
      io_clk_en     <= ~deep;
      main_clk_en   <= ~pd_ps | (debug_enable_fuse & scan_port_active)
                       | ~deep; // [R17]
    end
  end

  // ==================================================================
  // Scan port.

  assign scan_port_active = scan_port_enable_fuse &
                            ~ctl_q[`CTL_SCAN_DIS]; // [R18]

  // TDO belongs to the scan clock and is passed straight through.
  assign tdo_o  = tdo_data;
  assign tdo_oe = scan_port_active & tap_shifting; // [R19]

  // ==================================================================
  // APB slave.

  // Zero wait states: read data is captured in the setup cycle.
  wire mapped = (paddr == `REG_STATUS_FLAGS) || (paddr == `REG_SLEEP_CTRL) ||
                (paddr == `REG_CTRL) || (paddr == `REG_STATE);

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        `REG_STATUS_FLAGS: prdata <= {27'h0, flags_q};
        `REG_SLEEP_CTRL:   prdata <= {28'h0, slp_q};
        `REG_CTRL:         prdata <= {28'h0, ctl_q};
        `REG_STATE:        prdata <= {24'h0, stretch_q, hold, sleeping_q,
                                      scan_port_active, vref_en, bod_en,
                                      io_clk_en, main_clk_en};
        default:           prdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule
`default_nettype wire

// ### reset_sleep_ctrl_props.sv
// Concurrent checks on the reset and sleep control ports.
`timescale 1ns/1ps
`default_nettype none
module reset_sleep_ctrl_props (
  input wire logic        pclk,                  // system clock
  input wire logic        presetn,               // bus reset, active low
  input wire logic        psel,                  // APB select
  input wire logic        penable,               // APB enable
  input wire logic [11:0] paddr,                 // APB address
  input wire logic [31:0] prdata,                // APB read data
  input wire logic        pslverr,               // APB error
  input wire logic        supply_low,            // supply below level
  input wire logic        io_reset_n,            // I/O port reset
  input wire logic        cpu_reset_n,           // internal reset
  input wire logic        vector_load,           // vector load pulse
  input wire logic [15:0] vector_addr,           // vector address
  input wire logic        tap_shifting,          // TAP shifting
  input wire logic        tdo_oe,                // TDO enable
  input wire logic        scan_port_enable_fuse, // scan fuse
  input wire logic        scan_port_active,      // scan port on
  input wire logic [2:0]  brownout_level_fuses,  // brown-out fuses
  input wire logic        bod_active,            // detector power
  input wire logic        vref_en,               // reference power
  input wire logic        debug_enable_fuse,     // debug fuse
  input wire logic        main_clk_en            // main clock enable
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_por; supply_low |-> !io_reset_n; endproperty
  a_por: assert property (p_por) else $error("io reset not low");
  property p_hold; supply_low |-> ##[0:3] !cpu_reset_n; endproperty
  a_hold: assert property (p_hold) else $error("no hold");
  // The shortest time-out plus the two sync stages keeps reset 8 cycles.
  property p_stretch; $fell(supply_low) |-> !cpu_reset_n [*8]; endproperty
  a_stretch: assert property (p_stretch) else $error("short hold");
  property p_rel; $rose(cpu_reset_n) |-> !$past(supply_low, 6); endproperty
  a_rel: assert property (p_rel) else $error("early release");
  property p_vec;
    $rose(cpu_reset_n) |-> vector_load && vector_addr == 16'h0000;
  endproperty
  a_vec: assert property (p_vec) else $error("vector missing");
  property p_once; vector_load |=> !vector_load && cpu_reset_n; endproperty
  a_once: assert property (p_once) else $error("vector pulse long");
  property p_tdo; tdo_oe == (scan_port_active && tap_shifting); endproperty
  a_tdo: assert property (p_tdo) else $error("tdo driven idle");
  property p_scan; !scan_port_enable_fuse |-> !scan_port_active; endproperty
  a_scan: assert property (p_scan) else $error("scan port on");
  property p_bod;
    cpu_reset_n && $stable(brownout_level_fuses)
      && brownout_level_fuses != 3'h7 |-> bod_active && vref_en;
  endproperty
  a_bod: assert property (p_bod) else $error("detector off");
  property p_dbg;
    debug_enable_fuse && scan_port_active && $past(scan_port_active)
      |-> main_clk_en;
  endproperty
  a_dbg: assert property (p_dbg) else $error("main clock off");
  property p_err;
    psel && penable && paddr > 12'h00c |-> pslverr && prdata == 32'h0;
  endproperty
  a_err: assert property (p_err) else $error("unmapped not refused");
endmodule

bind reset_sleep_ctrl reset_sleep_ctrl_props props_i (
  .pclk, .presetn, .psel, .penable, .paddr, .prdata, .pslverr,
  .supply_low, .io_reset_n, .cpu_reset_n, .vector_load, .vector_addr,
  .tap_shifting, .tdo_oe, .scan_port_enable_fuse, .scan_port_active,
  .brownout_level_fuses, .bod_active, .vref_en, .debug_enable_fuse,
  .main_clk_en);
`default_nettype wire

// ### tb_reset_sleep_ctrl.sv
// Self-checking testbench for reset generation and sleep gating.
`timescale 1ns/1ps
`default_nettype none
`include "rst_regs.vh"
module tb_reset_sleep_ctrl;
  // ====================================================================
  // Signals
  logic        pclk = 1'b0;
  logic        presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        supply_low, rst_pin_n, wdt_timeout, bod_below;
  logic        scan_reset_bit, debug_enable_fuse, scan_port_enable_fuse;
  logic        sleep_cmd, wake_event, tap_shifting, tdo_data, io_reset_n;
  logic        cpu_reset_n, vector_load, tdo_o, tdo_oe, scan_port_active;
  logic        comparator_en, vref_en, bod_active, wdt_active;
  logic        input_buf_en, wake_buf_en, io_clk_en, main_clk_en;
  logic [15:0] vector_addr;
  logic [2:0]  brownout_level_fuses, m;
  logic [3:0]  clock_select_fuses;
  int          n_fail, checks, tout, n;
  logic [31:0] exp_q[$];
  string       name_q[$];
  int          tval[4] = '{6, 8, 10, 12};
  logic [2:0]  modes[5] = '{`SM_IDLE, `SM_PWR_DOWN, `SM_PWR_SAVE,
                            `SM_STANDBY, `SM_EXT_STBY};

  // Short time-outs keep every stretch within a few dozen cycles.
  reset_sleep_ctrl #(.TOUT0(24'd6), .TOUT1(24'd8), .TOUT2(24'd10),
    .TOUT3(24'd12)) reset_sleep_ctrl_i (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .supply_low,
    .rst_pin_n, .wdt_timeout, .bod_below, .scan_reset_bit,
    .brownout_level_fuses, .clock_select_fuses, .debug_enable_fuse,
    .scan_port_enable_fuse, .sleep_cmd, .wake_event, .tap_shifting,
    .tdo_data, .io_reset_n, .cpu_reset_n, .vector_load, .vector_addr,
    .tdo_o, .tdo_oe, .scan_port_active, .comparator_en, .vref_en,
    .bod_active, .wdt_active, .input_buf_en, .wake_buf_en, .io_clk_en,
    .main_clk_en);

  always #2.5 pclk = ~pclk;

  // ====================================================================
  // Tasks
  task automatic final_report;
    $display("checks %0d failures %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cyc(int k);
    repeat (k) @(posedge pclk);
  endtask

  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    int k;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 64);
    if (k >= 64) begin
      n_fail++;
      final_report();
    end
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(logic [11:0] a, logic [31:0] e, string nm);
    exp_q.push_back(e);
    name_q.push_back(nm);
    apb(1'b0, a, 32'h0);
  endtask

  task automatic wait_rel(output int c);
    c = 0;
    while (cpu_reset_n !== 1'b1 && c < 400) begin
      @(posedge pclk);
      c++;
    end
    if (c >= 400) begin
      n_fail++;
      final_report();
    end
  endtask

  // Bits of c: pin, watchdog, brown-out, scan; flags are left set.
  task automatic cause(logic [3:0] c, int len, logic [31:0] flg, logic hit);
    int k;
    {scan_reset_bit, bod_below, wdt_timeout} <= c[3:1];
    rst_pin_n <= !c[0];
    if (c[0]) begin
      #1;
      chk("io_reset_n", 0, io_reset_n);
    end
    cyc(len);
    chk("cpu_reset_n", !hit, cpu_reset_n);
    {scan_reset_bit, bod_below, wdt_timeout} <= 3'h0;
    rst_pin_n <= 1'b1;
    wait_rel(k);
    if (hit && len > 6)
      chk("stretch", 1, k >= tout + 2 && k <= tout + 7);
    rd(`REG_STATUS_FLAGS, flg, "flags");
  endtask

  // ====================================================================
  // Read checker: each completed read retires the oldest expectation.
  always @(posedge pclk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1
        && pwrite === 1'b0 && exp_q.size() > 0)
      chk(name_q.pop_front(), exp_q.pop_front(), prdata);
  end

  always @(posedge pclk) begin
    tdo_data     <= 1'($urandom);
    tap_shifting <= 1'($urandom);
  end

  // ====================================================================
  // Main sequence
  initial begin
    void'($urandom(78317));
    {psel, penable, pwrite, paddr, pwdata, wdt_timeout, bod_below} = '0;
    {scan_reset_bit, sleep_cmd, wake_event} = '0;
    {presetn, debug_enable_fuse} = '0;
    {supply_low, rst_pin_n, scan_port_enable_fuse} = 3'h7;
    brownout_level_fuses = `BOD_OFF;
    clock_select_fuses = 4'($urandom_range(15));
    tout = tval[clock_select_fuses[1:0]];
    cyc(16);
    presetn <= 1'b1;
    cyc(4);
    chk("por hold", 0, cpu_reset_n);
    supply_low <= 1'b0;
    wait_rel(n);
    chk("por stretch", 1, n >= tout + 2 && n <= tout + 7);
    rd(`REG_STATUS_FLAGS, 32'h1, "por flag");
    apb(1'b1, `REG_STATUS_FLAGS, 32'h0);
    rd(12'h010, 32'h0, "unmapped");
    apb(1'b1, `REG_CTRL, 32'h2);
    cyc(2);
    chk("wdt_active", 1, wdt_active);
    cause(4'h2, 6, 32'h8, 1);
    rd(`REG_CTRL, 32'h0, "ctrl cleared");
    cause(4'h2, 6, 32'h8, 0);
    apb(1'b1, `REG_STATUS_FLAGS, 32'h0);
    apb(1'b1, `REG_CTRL, 32'h4);
    cause(4'h1, 100, 32'h0, 0);
    rd(`REG_CTRL, 32'h0, "ctrl pin");
    cause(4'h1, 520, 32'h2, 1);
    apb(1'b1, `REG_STATUS_FLAGS, 32'h0);
    cause(4'h4, 20, 32'h0, 0);
    brownout_level_fuses <= 3'h4;
    cause(4'h4, 20, 32'h4, 1);
    chk("vref_en", 1, vref_en);
    cause(4'h8, 20, 32'h14, 1);
    supply_low <= 1'b1;
    cyc(5);
    supply_low <= 1'b0;
    wait_rel(n);
    rd(`REG_STATUS_FLAGS, 32'h1, "por clears");
    brownout_level_fuses <= `BOD_OFF;
    cyc(3);
    chk("vref off", 0, vref_en);
    apb(1'b1, `REG_CTRL, 32'h1);
    cyc(1);
    chk("scan off", 0, scan_port_active);
    scan_port_enable_fuse <= 1'b0;
    apb(1'b1, `REG_CTRL, 32'h8);
    cyc(1);
    chk("scan fuse", 0, scan_port_active);
    chk("tdo_o", tdo_data, tdo_o);
    scan_port_enable_fuse <= 1'b1;
    for (int p = 0; p < 2; p++) begin
      debug_enable_fuse <= p[0];
      foreach (modes[i]) begin
        m = modes[i];
        apb(1'b1, `REG_SLEEP_CTRL, {28'h0, 1'b1, m});
        @(posedge pclk);
        sleep_cmd <= 1'b1;
        @(posedge pclk);
        sleep_cmd <= 1'b0;
        cyc(3);
        chk("comparator_en", m == 0, comparator_en);
        chk("io_clk_en", m == 0, io_clk_en);
        chk("input_buf_en", m == 0, input_buf_en);
        chk("wake_buf_en", 1, wake_buf_en);
        chk("vref sleep", 1, vref_en);
        chk("main_clk_en", !(m == 2 || m == 3) || p == 1, main_clk_en);
        wake_event <= 1'b1;
        cyc(6);
        wake_event <= 1'b0;
        cyc(2);
        chk("awake", 1, io_clk_en);
      end
    end
    final_report();
  end
endmodule
`default_nettype wire
